// ==== sbcspi_top.sv ====
// serial register access front end: frame tracking, decode, register file
// assumes op_state, reset_output_n and status_set come from logic on clock;
// chip_select_n, serial_clock and wake_pins are asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module sbcspi_top #(
   parameter logic [7:0] FAMILY_PRODUCT_ID = 8'h5a // value is arbitrary
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic clock_en,
   input wire logic serial_clock,
   input wire logic chip_select_n,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_oe_n,
   input wire logic reset_output_n,
   input wire sbcspi_pkg::sbcspi_opstate_t op_state,
   input wire logic [sbcspi_pkg::NSTAT-1:0][7:0] status_set,
   input wire logic [7:0] wake_pins,
   output logic [sbcspi_pkg::NCTRL-1:0][7:0] ctrl_value,
   output logic [sbcspi_pkg::NSTAT-1:0][7:0] status_value,
   output logic [7:0] summary,
   output logic frame_error
);
   import sbcspi_pkg::*;

   // pin synchronisers
   logic cs_sync;
   logic sclk_sync;
   logic [7:0] wake_sync;

   // link side
   logic link_clr_reg;
   logic [6:0] rd_addr;
   logic [7:0] rd_data;
   logic [15:0] frame_word;
   logic [4:0] fall_cnt;
   logic [4:0] rise_cnt;

   // register file and its frozen copy for the link
   sbcspi_byte_t ctrl_reg [NCTRL];
   sbcspi_byte_t stat_reg [NSTAT];
   sbcspi_byte_t snap_ctrl_reg [NCTRL];
   sbcspi_byte_t snap_stat_reg [NSTAT];
   logic [7:0] snap_level_reg;
   logic [7:0] summary_reg;
   logic [7:0] summary_next;
   logic err_reg;

   // frame tracking
   sbcspi_frame_t frame_reg;
   sbcspi_frame_t frame_next;
   logic edge_bad_reg;
   logic rst_low_reg;
   sbcspi_opstate_t state_prev_reg;

   // decode of the finished frame
   logic [6:0] frame_addr;
   logic frame_access;
   logic [7:0] frame_data;
   logic clocks_none;
   logic clocks_ok;
   logic frame_bad;
   logic listening;
   logic cfg_allowed;
   logic frame_exec;
   logic err_set;
   logic ctrl_wr;
   logic stat_clr;
   logic mode_change;
   int wr_ci;
   int wr_si;
   int rd_ci;
   int rd_si;

   sbcspi_sync #(
      .WIDTH(1),
      .RESET_VAL(1'b1)
   ) u_cs_sync (
      .clock(clock),
      .rst(rst),
      .clock_en(clock_en),
      .d(chip_select_n),
      .q(cs_sync)
   );

   // the serial clock level is watched only to catch it high at select edges
   sbcspi_sync #(
      .WIDTH(9),
      .RESET_VAL(9'h000)
   ) u_pin_sync (
      .clock(clock),
      .rst(rst),
      .clock_en(clock_en),
      .d({wake_pins, serial_clock}),
      .q({wake_sync, sclk_sync})
   );

   sbcspi_link u_link (
      .serial_clock(serial_clock),
      .link_clr(link_clr_reg),
      .chip_select_n(chip_select_n),
      .serial_in(serial_in),
      .reset_output_n(reset_output_n),
      .err_flag(err_reg),
      .summary(summary_reg),
      .rd_data(rd_data),
      .rd_addr(rd_addr),
      .frame_word(frame_word),
      .fall_count(fall_cnt),
      .rise_count(rise_cnt),
      .serial_out(serial_out),
      .serial_out_oe_n(serial_out_oe_n)
   );

   // read mux over the frozen copy; stable for the whole frame, so the link
   // may use it directly without a further crossing
   always_comb begin
      rd_ci = ctrl_index(rd_addr);
      rd_si = stat_index(rd_addr);
      rd_data = 8'h00;
      if (rd_ci >= 0) begin
         rd_data = snap_ctrl_reg[rd_ci];
      end else if (rd_si >= 0) begin
         rd_data = snap_stat_reg[rd_si];
      end else if (rd_addr == LEVEL_ADDR) begin
         rd_data = snap_level_reg;
      end else if (rd_addr == ID_ADDR) begin
         rd_data = FAMILY_PRODUCT_ID;
      end
   end

   // summary byte from the live status registers, level register left out
   always_comb begin
      summary_next[0] = |(stat_reg[SI_SUP_A] | stat_reg[SI_SUP_B]);
      summary_next[1] = |stat_reg[SI_THERM];
      summary_next[2] = |stat_reg[SI_DEV];
      summary_next[3] = |stat_reg[SI_TRX0];
      summary_next[4] = |(stat_reg[SI_TRX12] | stat_reg[SI_TRX3]);
      summary_next[5] = |stat_reg[SI_WAKE_A];
      summary_next[6] = |stat_reg[SI_WAKE_B];
      summary_next[7] = |stat_reg[SI_SMPS];
   end

   // snapshot follows the live registers only between frames; a set landing
   // during a frame shows in the next one
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NCTRL; i++) begin
            snap_ctrl_reg[i] <= CTRL_RESET;
         end
         for (int i = 0; i < NSTAT; i++) begin
            snap_stat_reg[i] <= STAT_RESET;
         end
         snap_level_reg <= 8'h00;
         summary_reg <= 8'h00;
      end else if (clock_en && frame_reg == FR_IDLE && cs_sync) begin
         snap_ctrl_reg <= ctrl_reg;
         snap_stat_reg <= stat_reg;
         snap_level_reg <= wake_sync;
         summary_reg <= summary_next;
      end
   end

   // frame state: idle with link cleared, active while select low, done once
   always_comb begin
      frame_next = frame_reg;
      case (frame_reg)
         FR_IDLE: begin
            if (!cs_sync) begin
               frame_next = FR_ACTIVE;
            end
         end
         FR_ACTIVE: begin
            if (cs_sync) begin
               frame_next = FR_DONE;
            end
         end
         FR_DONE: frame_next = FR_IDLE;
         default: frame_next = FR_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         frame_reg <= FR_IDLE;
      end else if (clock_en) begin
         frame_reg <= frame_next;
      end
   end

   // link held cleared between frames; released as soon as select is seen low
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         link_clr_reg <= 1'b1;
      end else if (clock_en) begin
         link_clr_reg <= (frame_next == FR_IDLE) && cs_sync;
      end
   end

   // conditions gathered while the frame runs
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         edge_bad_reg <= 1'b0;
         rst_low_reg <= 1'b0;
      end else if (clock_en) begin
         if (frame_reg == FR_IDLE) begin
            edge_bad_reg <= !cs_sync && sclk_sync;
            rst_low_reg <= !reset_output_n;
         end else if (frame_reg == FR_ACTIVE) begin
            if (cs_sync && sclk_sync) begin
               edge_bad_reg <= 1'b1;
            end
            if (!reset_output_n) begin
               rst_low_reg <= 1'b1;
            end
         end
      end
   end

   // judging the finished frame; counts are quiet since the clock has stopped
   always_comb begin
      frame_addr = frame_word[ADDR_LSB +: ADDR_W];
      frame_access = frame_word[ACCESS_BIT];
      frame_data = frame_word[DATA_LSB +: DATA_W];
      wr_ci = ctrl_index(frame_addr);
      wr_si = stat_index(frame_addr);
      clocks_none = (fall_cnt == 5'h00) && (rise_cnt == 5'h00);
      clocks_ok = (fall_cnt == FRAME_CLOCKS) && (rise_cnt == FRAME_CLOCKS);
      frame_bad = (!clocks_none && !clocks_ok) || edge_bad_reg || rst_low_reg;
      listening = !(op_state inside {OP_RESTART, OP_SLEEP, OP_FAILSAFE});
      cfg_allowed = (op_state == OP_NORMAL) || (op_state == OP_INIT);
      frame_exec = (frame_reg == FR_DONE) && clocks_ok && !frame_bad && listening;
      err_set = (frame_reg == FR_DONE) &&
                (frame_bad || (op_state == OP_FAILSAFE && !clocks_none));
      ctrl_wr = frame_exec && frame_access && (wr_ci >= 0) && cfg_allowed;
      stat_clr = frame_exec && frame_access && (wr_si >= 0);
      mode_change = op_state != state_prev_reg;
   end

   // error flag: a bad frame sets it, a good full frame clears it except in restart, sleep and fail-safe
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         err_reg <= 1'b0;
      end else if (clock_en) begin
         if (err_set) begin
            err_reg <= 1'b1;
         end else if (frame_exec) begin
            err_reg <= 1'b0;
         end
      end
   end

   // status registers: hardware sets win over a clear in the same cycle
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NSTAT; i++) begin
            stat_reg[i] <= STAT_RESET;
         end
      end else if (clock_en) begin
         for (int i = 0; i < NSTAT; i++) begin
            if (stat_clr && wr_si == i) begin
               stat_reg[i] <= status_set[i];
            end else begin
               stat_reg[i] <= stat_reg[i] | status_set[i];
            end
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_prev_reg <= OP_INIT;
      end else if (clock_en) begin
         state_prev_reg <= op_state;
      end
   end

   // control registers: writes after select rises, then mode-entry rewrites
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NCTRL; i++) begin
            ctrl_reg[i] <= CTRL_RESET;
         end
      end else if (clock_en) begin
         for (int i = 0; i < NCTRL; i++) begin
            if (ctrl_wr && wr_ci == i) begin
               ctrl_reg[i] <= frame_data;
            end
         end
         if (mode_change) begin
            ctrl_reg[IDX_MODE][MODE_LSB +: 2] <= mode_field(op_state);
            if (op_state == OP_SLEEP) begin
               // fail output bit is left alone, so a triggered one stays on
               if (ctrl_reg[IDX_TRX0][TRX_A_LSB +: 2] == TRX_ON) begin
                  ctrl_reg[IDX_TRX0][TRX_A_LSB +: 2] <= TRX_WAKE;
               end
               if (ctrl_reg[IDX_TRX12][TRX_A_LSB +: 2] == TRX_ON) begin
                  ctrl_reg[IDX_TRX12][TRX_A_LSB +: 2] <= TRX_WAKE;
               end
               if (ctrl_reg[IDX_TRX12][TRX_B_LSB +: 2] == TRX_ON) begin
                  ctrl_reg[IDX_TRX12][TRX_B_LSB +: 2] <= TRX_WAKE;
               end
               if (ctrl_reg[IDX_TRX3][TRX_A_LSB +: 2] == TRX_ON) begin
                  ctrl_reg[IDX_TRX3][TRX_A_LSB +: 2] <= TRX_WAKE;
               end
            end
         end
      end
   end

   // outputs straight from registers
   always_comb begin
      for (int i = 0; i < NCTRL; i++) begin
         ctrl_value[i] = ctrl_reg[i];
      end
      for (int i = 0; i < NSTAT; i++) begin
         status_value[i] = stat_reg[i];
      end
   end

   assign summary = summary_reg;
   assign frame_error = err_reg;

endmodule
`default_nettype wire

// ==== sbcspi_pkg.sv ====
// constants, types and helper functions for the serial register access block
// assumes one system clock domain plus the serial clock domain of the link
package sbcspi_pkg;

   localparam int NCTRL = 12;
   localparam int NSTAT = 11;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int FRAME_W = 16;
   localparam int CNT_W = 5;
   localparam int ACCESS_BIT = 7;
   localparam int ADDR_LSB = 0;
   localparam int DATA_LSB = 8;
   localparam logic [4:0] FRAME_CLOCKS = 5'h10;
   localparam logic [4:0] BYTE_CLOCKS = 5'h08;
   localparam logic [4:0] CNT_MAX = 5'h1f;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] STAT_RESET = 8'h00;

   // decode ranges of the two register classes
   localparam logic [6:0] CTRL_FIRST = 7'h01;
   localparam logic [6:0] CTRL_LAST = 7'h3f;
   localparam logic [6:0] STAT_FIRST = 7'h40;
   localparam logic [6:0] STAT_LAST = 7'h7e;

   // mapped offsets, index order is the order of the register arrays
   localparam logic [6:0] CTRL_ADDR [NCTRL] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h06, 7'h07,
                                               7'h08, 7'h0a, 7'h0b, 7'h0c, 7'h0e, 7'h1e};
   localparam logic [6:0] STAT_ADDR [NSTAT] = '{7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h46,
                                               7'h49, 7'h4a, 7'h4b, 7'h4c, 7'h58};
   localparam logic [6:0] LEVEL_ADDR = 7'h48;
   localparam logic [6:0] ID_ADDR = 7'h7e;

   // control register indices and fields touched by mode transitions
   localparam int IDX_MODE = 0;
   localparam int IDX_TRX0 = 3;
   localparam int IDX_TRX12 = 7;
   localparam int IDX_TRX3 = 8;
   localparam int MODE_LSB = 6;
   localparam int TRX_A_LSB = 0;
   localparam int TRX_B_LSB = 3;
   localparam logic [1:0] TRX_ON = 2'h3;
   localparam logic [1:0] TRX_WAKE = 2'h1;
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_SLEEP = 2'h1;
   localparam logic [1:0] MODE_STOP = 2'h2;
   localparam logic [1:0] MODE_RESET = 2'h3;

   // status register indices
   localparam int SI_SUP_B = 0;
   localparam int SI_SUP_A = 1;
   localparam int SI_THERM = 2;
   localparam int SI_DEV = 3;
   localparam int SI_TRX0 = 4;
   localparam int SI_WAKE_A = 5;
   localparam int SI_WAKE_B = 6;
   localparam int SI_TRX12 = 7;
   localparam int SI_TRX3 = 8;
   localparam int SI_SMPS = 9;

   typedef enum logic [2:0] {
      OP_INIT = 3'h0,
      OP_NORMAL = 3'h1,
      OP_STOP = 3'h2,
      OP_SLEEP = 3'h3,
      OP_RESTART = 3'h4,
      OP_FAILSAFE = 3'h5
   } sbcspi_opstate_t;

   // frame tracking in the system domain, gray along idle-active-done
   typedef enum logic [1:0] {
      FR_IDLE = 2'b00,
      FR_ACTIVE = 2'b01,
      FR_DONE = 2'b11
   } sbcspi_frame_t;

   typedef logic [7:0] sbcspi_byte_t;

   // control index of an address, -1 when not a mapped control register
   function automatic int ctrl_index(input logic [6:0] addr);
      int idx;
      idx = -1;
      if (addr >= CTRL_FIRST && addr <= CTRL_LAST) begin
         for (int i = 0; i < NCTRL; i++) begin
            if (CTRL_ADDR[i] == addr) begin
               idx = i;
            end
         end
      end
      return idx;
   endfunction

   // status index of an address, -1 when not a clearable status register
   function automatic int stat_index(input logic [6:0] addr);
      int idx;
      idx = -1;
      if (addr >= STAT_FIRST && addr <= STAT_LAST) begin
         for (int i = 0; i < NSTAT; i++) begin
            if (STAT_ADDR[i] == addr) begin
               idx = i;
            end
         end
      end
      return idx;
   endfunction

   // mode field value for the operating state actually entered
   function automatic logic [1:0] mode_field(input sbcspi_opstate_t st);
      logic [1:0] f;
      case (st)
         OP_SLEEP: f = MODE_SLEEP;
         OP_STOP: f = MODE_STOP;
         OP_RESTART, OP_FAILSAFE: f = MODE_RESET;
         default: f = MODE_NORMAL;
      endcase
      return f;
   endfunction

endpackage

// ==== sbcspi_sync.sv ====
// two flip-flop synchroniser for levels arriving from another domain
// assumes the destination clock and its asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module sbcspi_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic clock_en,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   // first stage feeds only the second stage
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meta_reg <= RESET_VAL;
         sync_reg <= RESET_VAL;
      end else if (clock_en) begin
         meta_reg <= d;
         sync_reg <= meta_reg;
      end
   end

   assign q = sync_reg;

endmodule
`default_nettype wire

// ==== sbcspi_link.sv ====
// serial shift logic on the master's serial clock
// assumes the clock idles low and stops while select is high;
// link_clr comes from the system domain and is released only with select low
`timescale 1ns/1ps
`default_nettype none
module sbcspi_link (
   input wire logic serial_clock,
   input wire logic link_clr,
   input wire logic chip_select_n,
   input wire logic serial_in,
   input wire logic reset_output_n,
   input wire logic err_flag,
   input wire logic [7:0] summary,
   input wire logic [7:0] rd_data,
   output logic [6:0] rd_addr,
   output logic [15:0] frame_word,
   output logic [4:0] fall_count,
   output logic [4:0] rise_count,
   output logic serial_out,
   output logic serial_out_oe_n
);
   import sbcspi_pkg::*;

   logic [15:0] word_reg;
   logic [4:0] fall_reg;
   logic [4:0] rise_reg;
   logic [7:0] sh_reg;
   logic out_reg;

   // capture on falling edges, first bit ends up in bit 0
   always_ff @(negedge serial_clock or posedge link_clr) begin
      if (link_clr) begin
         word_reg <= '0;
         fall_reg <= '0;
      end else begin
         word_reg <= {serial_in, word_reg[15:1]};
         if (fall_reg != CNT_MAX) begin
            fall_reg <= fall_reg + 5'h01;
         end
      end
   end

   // shift out after rising edges: summary byte first, then register data
   always_ff @(posedge serial_clock or posedge link_clr) begin
      if (link_clr) begin
         rise_reg <= '0;
         sh_reg <= '0;
         out_reg <= 1'b0;
      end else begin
         if (rise_reg != CNT_MAX) begin
            rise_reg <= rise_reg + 5'h01;
         end
         if (rise_reg == 5'h00) begin
            out_reg <= summary[0];
            sh_reg <= {1'b0, summary[7:1]};
         end else if (rise_reg == BYTE_CLOCKS) begin
            out_reg <= rd_data[0];
            sh_reg <= {1'b0, rd_data[7:1]};
         end else begin
            out_reg <= sh_reg[0];
            sh_reg <= {1'b0, sh_reg[7:1]};
         end
      end
   end

   // address is complete once eight bits are in, before the ninth rising edge
   assign rd_addr = word_reg[14:8];
   assign frame_word = word_reg;
   assign fall_count = fall_reg;
   assign rise_count = rise_reg;

   // error flag shown before the first rising edge; forced high during reset
   assign serial_out = !reset_output_n ? 1'b1 :
                       (rise_reg == 5'h00) ? err_flag : out_reg;
   // released the moment select rises
   assign serial_out_oe_n = chip_select_n;

endmodule
`default_nettype wire

// ==== sbcspi_master.sv ====
// serial master model that drives select, serial clock and data in
// assumes the device answers after rising and samples on falling edges
`timescale 1ns/1ps
`default_nettype none
module sbcspi_master (
   output logic serial_clock,
   output logic chip_select_n,
   output logic serial_in,
   input wire logic serial_out
);
   // clock stands low outside frames
   initial begin
      serial_clock = 1'b0;
      chip_select_n = 1'b1;
      serial_in = 1'b0;
   end
   // one frame of n clocks, lsb first, 48 ns period
   task automatic xfer(input logic [15:0] w, input int n, output logic err, output logic [15:0] r);
      r = '0;
      chip_select_n = 1'b0;
      #40;
      err = serial_out;
      // data moves mid-low, never in the time step of the sampling fall
      for (int i = 0; i < n; i++) begin
         #12 serial_in = w[i%16];
         #12 serial_clock = 1'b1;
         #12 r[i%16] = serial_out;
         #12 serial_clock = 1'b0;
      end
      // no stale level left on the data line
      #12 serial_in = ~serial_in;
      #18 chip_select_n = 1'b1;
      #60;
   endtask
   // frames begun in reset are issued here as well, and the device discards their data
endmodule
`default_nettype wire

// ==== sbcspi_monitor.sv ====
// concurrent checks on the ports of the serial register access block
// assumes bound onto sbcspi_top, system clock domain only
`timescale 1ns/1ps
`default_nettype none
module sbcspi_monitor (
   input wire logic clock,
   input wire logic rst,
   input wire logic chip_select_n,
   input wire logic serial_out,
   input wire logic serial_out_oe_n,
   input wire logic reset_output_n,
   input wire sbcspi_pkg::sbcspi_opstate_t op_state,
   input wire logic [sbcspi_pkg::NCTRL-1:0][7:0] ctrl_value,
   input wire logic [sbcspi_pkg::NSTAT-1:0][7:0] status_value,
   input wire logic [7:0] summary,
   input wire logic frame_error
);
   import sbcspi_pkg::*;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // expected summary, pairs ORed, level register left out
   function automatic logic [7:0] fold(input logic [NSTAT-1:0][7:0] s);
      return {|s[SI_SMPS], |s[SI_WAKE_B], |s[SI_WAKE_A], (|s[SI_TRX12]) | (|s[SI_TRX3]),
              |s[SI_TRX0], |s[SI_DEV], |s[SI_THERM], (|s[SI_SUP_A]) | (|s[SI_SUP_B])};
   endfunction
   // long quiet stretch so a summary held between frames has settled
   sequence s_quiet;
      (chip_select_n && $stable(status_value)) [*8];
   endsequence
   sequence s_busy;
      (!chip_select_n && $stable(op_state)) [*5];
   endsequence
   sequence s_frame_rst;
      (!chip_select_n && !reset_output_n) ##1 chip_select_n;
   endsequence
   a_oe_tracks_sel: assert property (serial_out_oe_n == chip_select_n)
      else $error("output enable does not follow select");
   a_out_high_rst: assert property (!reset_output_n |-> serial_out)
      else $error("serial out low while reset output low");
   a_summary_map: assert property (s_quiet |-> summary == fold(status_value))
      else $error("summary byte mismatch");
   a_status_kept: assert property (s_busy |-> (status_value & $past(status_value)) == $past(status_value))
      else $error("status bit cleared itself");
   a_ctrl_frozen: assert property (s_busy |-> $stable(ctrl_value))
      else $error("control changed during frame");
   a_mode_field: assert property ($stable(op_state) [*3] |-> ctrl_value[IDX_MODE][7:6] == mode_field(op_state))
      else $error("mode field wrong");
   a_sleep_wake: assert property ($changed(op_state) && op_state == OP_SLEEP && $past(ctrl_value[IDX_TRX0][1:0]) == TRX_ON
      |-> ##[0:3] ctrl_value[IDX_TRX0][1:0] == TRX_WAKE)
      else $error("transceiver field not wake capable");
   a_err_in_rst: assert property (s_frame_rst |-> ##[1:8] frame_error)
      else $error("frame error not set");
endmodule
bind sbcspi_top sbcspi_monitor mon_u (.clock(clock), .rst(rst), .chip_select_n(chip_select_n),
   .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n), .reset_output_n(reset_output_n),
   .op_state(op_state), .ctrl_value(ctrl_value), .status_value(status_value), .summary(summary),
   .frame_error(frame_error));
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the serial register access block
// assumes the master model drives the link; clock_en held high
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sbcspi_pkg::*;
   logic clock, rst, serial_clock, chip_select_n, serial_in, serial_out, serial_out_oe_n, reset_output_n, frame_error;
   sbcspi_opstate_t op_state;
   logic [NSTAT-1:0][7:0] status_set, status_value;
   logic [NCTRL-1:0][7:0] ctrl_value;
   logic [7:0] wake_pins, summary;
   logic [15:0] r;
   logic e;
   int err_total, tests_run;
   int smap [10] = '{0, 0, 1, 2, 3, 5, 6, 4, 4, 7};
   sbcspi_top dut_u (.clock(clock), .rst(rst), .clock_en(1'b1), .serial_clock(serial_clock),
      .chip_select_n(chip_select_n), .serial_in(serial_in), .serial_out(serial_out),
      .serial_out_oe_n(serial_out_oe_n), .reset_output_n(reset_output_n), .op_state(op_state),
      .status_set(status_set), .wake_pins(wake_pins), .ctrl_value(ctrl_value),
      .status_value(status_value), .summary(summary), .frame_error(frame_error));
   sbcspi_master m_u (.serial_clock(serial_clock), .chip_select_n(chip_select_n), .serial_in(serial_in),
      .serial_out(serial_out));
   // compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one frame, launched off the system clock falling edge
   task automatic fr(input logic [6:0] a, input logic acc, input logic [7:0] d, input int n);
      @(negedge clock);
      m_u.xfer({d, acc, a}, n, e, r);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // 200 MHz system clock
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // watchdog, well past the roughly 50 frames of the run
   initial begin
      #200000;
      err_total++;
      results();
   end
   // main sequence
   initial begin
      rst = 1'b1;
      reset_output_n = 1'b1;
      op_state = OP_NORMAL;
      status_set = '0;
      wake_pins = 8'h00;
      repeat (6) @(negedge clock);
      rst = 1'b0;
      repeat (4) @(negedge clock);
      fr(7'h02, 1'b1, 8'ha5, 16); chk(r, 16'h0000);
      fr(7'h02, 1'b0, 8'h00, 16); chk(r, 16'ha500);
      $display("test control done");
      for (int i = 0; i < 10; i++) begin
         @(negedge clock); status_set[i] = 8'h81;
         @(negedge clock); status_set[i] = 8'h00;
         repeat (12) @(negedge clock);
         chk(summary, 8'h01 << smap[i]);
         fr(STAT_ADDR[i], 1'b0, 8'h00, 16); chk(r, {8'h81, 8'h01 << smap[i]});
         fr(STAT_ADDR[i], 1'b1, 8'h00, 16); chk(r[15:8], 8'h81);
         fr(STAT_ADDR[i], 1'b0, 8'h00, 16); chk(r, 16'h0000);
      end
      @(negedge clock); status_set[SI_SUP_A] = 8'h01; status_set[SI_SUP_B] = 8'h02;
      @(negedge clock); status_set = '0;
      fr(STAT_ADDR[SI_SUP_A], 1'b1, 8'h00, 16);
      fr(STAT_ADDR[SI_SUP_B], 1'b1, 8'h00, 16); chk(r, 16'h0201);
      fr(STAT_ADDR[SI_SUP_B], 1'b0, 8'h00, 16); chk(r, 16'h0000);
      @(negedge clock); wake_pins = 8'h3c;
      fr(LEVEL_ADDR, 1'b1, 8'h00, 16);
      fr(LEVEL_ADDR, 1'b0, 8'h00, 16); chk(r, 16'h3c00);
      for (int i = 0; i < 2; i++) begin
         fr(i ? 7'h50 : 7'h05, 1'b1, 8'hff, 16);
         fr(i ? 7'h50 : 7'h05, 1'b0, 8'h00, 16); chk(r, 16'h0000);
      end
      $display("test status done");
      fr(7'h02, 1'b1, 8'h3c, 5);
      fr(7'h00, 1'b0, 8'h00, 0); chk({e, frame_error, ctrl_value[1]}, 16'h03a5);
      fr(7'h02, 1'b0, 8'h00, 16); chk(e, 1'b1);
      fr(7'h02, 1'b0, 8'h00, 16); chk(e, 1'b0);
      // restart: reset output low, frame must not be taken
      @(negedge clock); reset_output_n = 1'b0; op_state = OP_RESTART;
      repeat (4) @(negedge clock);
      chk(ctrl_value[IDX_MODE][7:6], MODE_RESET);
      fr(7'h03, 1'b1, 8'h11, 16); chk(r, 16'hffff);
      @(negedge clock); reset_output_n = 1'b1; op_state = OP_NORMAL;
      repeat (4) @(negedge clock);
      chk({7'h00, frame_error, ctrl_value[2]}, 16'h0100);
      chk(ctrl_value[IDX_MODE], 8'h00);
      fr(7'h03, 1'b0, 8'h00, 16); chk({e, r[15:8]}, 16'h0100);
      $display("test error done");
      fr(7'h04, 1'b1, 8'h03, 16);
      @(negedge clock); op_state = OP_SLEEP;
      repeat (4) @(negedge clock);
      chk({ctrl_value[IDX_MODE], ctrl_value[IDX_TRX0]}, 16'h4001);
      fr(7'h04, 1'b1, 8'h00, 16); chk(ctrl_value[IDX_TRX0], 8'h01);
      @(negedge clock); op_state = OP_STOP;
      fr(7'h06, 1'b1, 8'h55, 16); chk(ctrl_value[4], 8'h00);
      // fail-safe: clocked frame is ignored but flags the error
      @(negedge clock); op_state = OP_FAILSAFE;
      fr(7'h06, 1'b1, 8'h55, 16); chk({7'h00, frame_error, ctrl_value[4]}, 16'h0100);
      @(negedge clock); op_state = OP_NORMAL;
      fr(7'h06, 1'b0, 8'h00, 16); chk({e, r[15:8]}, 16'h0100);
      $display("test modes done");
      results();
   end
endmodule
`default_nettype wire
